// file: hw/aperture_pkg.sv
// Purpose: Constants for the processor address aperture decoder.
// Assumes: 32-bit byte addresses, 32-bit register bus data.
// Notes:   Register offsets are word aligned byte addresses.
package aperture_pkg;
    localparam int          ADDR_W             = 32;
    localparam int          DATA_W             = 32;
    localparam int          RADDR_W            = 8;
    localparam logic [31:0] HOLE_LAST          = 32'h0000_00ff;
    localparam logic [31:0] DRAM_MAX_SIZE      = 32'h0400_0000;
    localparam logic [31:0] REG_APERTURE_SIZE  = 32'h0020_0000;
    localparam logic [31:0] REG_APERTURE_RESET = 32'hefe0_0000;
    localparam logic [31:0] DRAM_BASE_RESET    = 32'h0000_0000;
    localparam logic [31:0] DRAM_LIMIT_RESET   = 32'h0000_0000;
    localparam logic [7:0]  OFS_DRAM_BASE      = 8'h00;
    localparam logic [7:0]  OFS_DRAM_LIMIT     = 8'h04;
    localparam logic [7:0]  OFS_REG_APERTURE   = 8'h08;
    localparam logic [7:0]  OFS_LOCK_CONTROL   = 8'h0c;
    localparam logic [7:0]  OFS_STATUS         = 8'h10;
    localparam logic [7:0]  OFS_ICACHE_TAG     = 8'h14;
    localparam int          BIT_HOLE_DISABLE   = 0;
    localparam int          BIT_PCI_DISABLE    = 1;
    localparam logic [1:0]  LOCK_CONTROL_RESET = 2'h0;
    localparam int          TIMEOUT_US         = 1;
    localparam int          CLK_MHZ            = 50;
    localparam int          TIMEOUT_CYCLES     = TIMEOUT_US * CLK_MHZ;
    localparam int          TMO_W              = 6;
    localparam logic [31:0] ICACHE_TAG_VALUE   = 32'h0000_0000;
    typedef enum logic [1:0] {
        TGT_HOLE,
        TGT_DRAM,
        TGT_REG,
        TGT_PCI
    } target_e;
endpackage : aperture_pkg

// file: hw/aperture_decoder.sv
// Purpose: Route processor loads and stores to hole, DRAM, register space or PCI.
// Assumes: One access request pulse per cycle from the load/store unit.
// Notes:   Decode is registered, so selects appear one cycle after the request.
`timescale 1ns/1ps
module aperture_decoder (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST,
    input  wire logic        I_REQ,
    input  wire logic        I_WRITE,
    input  wire logic [31:0] I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_BYTE_ORDER_SELECT,
    input  wire logic [7:0]  I_REG_ADDR,
    input  wire logic [31:0] I_REG_WDATA,
    input  wire logic        I_REG_WR,
    input  wire logic        I_REG_RD,
    output logic [31:0]      O_REG_RDATA,
    output logic             O_SEL_HOLE,
    output logic             O_SEL_DRAM,
    output logic             O_SEL_REG,
    output logic             O_SEL_PCI,
    output logic             O_SEL_NONE,
    output logic             O_WRITE,
    output logic [31:0]      O_ADDR,
    output logic [31:0]      O_WDATA,
    output logic             O_SWAP,
    output logic             O_LOAD_ZERO,
    output logic             O_REG_TIMEOUT
);
    logic [31:0] dram_base_q;
    logic [31:0] dram_base_d;
    logic [31:0] dram_limit_q;
    logic [31:0] dram_limit_d;
    logic [31:0] reg_start_q;
    logic [31:0] reg_start_d;
    logic [1:0]  lock_ctl_q;
    logic [1:0]  lock_ctl_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        hole_q;
    logic        hole_d;
    logic        dram_q;
    logic        dram_d;
    logic        regs_q;
    logic        regs_d;
    logic        pci_q;
    logic        pci_d;
    logic        none_q;
    logic        none_d;
    logic        wr_q;
    logic        wr_d;
    logic        swap_q;
    logic        swap_d;
    logic        zero_q;
    logic        zero_d;
    logic [31:0] addr_q;
    logic [31:0] addr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [5:0]  tmo_cnt_q;
    logic [5:0]  tmo_cnt_d;
    logic        tmo_q;
    logic        tmo_d;
    logic        in_hole;
    logic        in_dram;
    logic        in_reg;
    logic        hole_active;
    logic        dram_over_hole;
    logic [31:0] reg_offset;

    // Register file for the aperture bases and lock control.
    always_comb begin
        dram_base_d  = dram_base_q;
        dram_limit_d = dram_limit_q;
        reg_start_d  = reg_start_q;
        lock_ctl_d   = lock_ctl_q;
        rdata_d      = rdata_q;
        if (I_REG_WR) begin
            if (I_REG_ADDR == aperture_pkg::OFS_DRAM_BASE) begin
                dram_base_d = I_REG_WDATA;
            end else if (I_REG_ADDR == aperture_pkg::OFS_DRAM_LIMIT) begin
                dram_limit_d = I_REG_WDATA;
            end else if (I_REG_ADDR == aperture_pkg::OFS_REG_APERTURE) begin
                reg_start_d = I_REG_WDATA & ~(aperture_pkg::REG_APERTURE_SIZE - 32'h1);
            end else if (I_REG_ADDR == aperture_pkg::OFS_LOCK_CONTROL) begin
                lock_ctl_d = I_REG_WDATA[1:0];
            end
        end
        if (I_REG_RD) begin
            if (I_REG_ADDR == aperture_pkg::OFS_DRAM_BASE) begin
                rdata_d = dram_base_q;
            end else if (I_REG_ADDR == aperture_pkg::OFS_DRAM_LIMIT) begin
                rdata_d = dram_limit_q;
            end else if (I_REG_ADDR == aperture_pkg::OFS_REG_APERTURE) begin
                rdata_d = reg_start_q;
            end else if (I_REG_ADDR == aperture_pkg::OFS_LOCK_CONTROL) begin
                rdata_d = {30'h0, lock_ctl_q};
            end else if (I_REG_ADDR == aperture_pkg::OFS_STATUS) begin
                rdata_d = {28'h0, dram_over_hole, hole_active, tmo_q, lock_ctl_q[1]};
            end else if (I_REG_ADDR == aperture_pkg::OFS_ICACHE_TAG) begin
                rdata_d = aperture_pkg::ICACHE_TAG_VALUE;
            end else begin
                rdata_d = 32'h0;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            dram_base_q  <= aperture_pkg::DRAM_BASE_RESET;
            dram_limit_q <= aperture_pkg::DRAM_LIMIT_RESET;
            reg_start_q  <= aperture_pkg::REG_APERTURE_RESET;
            lock_ctl_q   <= aperture_pkg::LOCK_CONTROL_RESET;
            rdata_q      <= 32'h0;
        end else begin
            dram_base_q  <= dram_base_d;
            dram_limit_q <= dram_limit_d;
            reg_start_q  <= reg_start_d;
            lock_ctl_q   <= lock_ctl_d;
            rdata_q      <= rdata_d;
        end
    end

    // Aperture decode; the DRAM compare is capped so a bad limit cannot exceed 64 MB.
    // A DRAM base inside the hole turns the hole off, however small the aperture is.
    always_comb begin
        reg_offset     = I_ADDR - reg_start_q;
        in_dram        = (I_ADDR >= dram_base_q) && (I_ADDR <= dram_limit_q)
                         && ((I_ADDR - dram_base_q) < aperture_pkg::DRAM_MAX_SIZE);
        in_reg         = reg_offset < aperture_pkg::REG_APERTURE_SIZE;
        in_hole        = I_ADDR <= aperture_pkg::HOLE_LAST;
        dram_over_hole = dram_base_q <= aperture_pkg::HOLE_LAST;
        hole_active    = !lock_ctl_q[aperture_pkg::BIT_HOLE_DISABLE] && !dram_over_hole;
    end

    // Target selection: hole wins for loads only, then DRAM, register space, PCI.
    always_comb begin
        hole_d  = 1'b0;
        dram_d  = 1'b0;
        regs_d  = 1'b0;
        pci_d   = 1'b0;
        none_d  = 1'b0;
        zero_d  = 1'b0;
        wr_d    = I_WRITE;
        addr_d  = I_ADDR;
        wdata_d = I_WDATA;
        swap_d  = I_BYTE_ORDER_SELECT;
        if (I_REQ) begin
            if (in_hole && hole_active && !I_WRITE) begin
                hole_d = 1'b1;
                zero_d = 1'b1;
            end else if (in_dram) begin
                dram_d = 1'b1;
            end else if (in_reg) begin
                regs_d = 1'b1;
                swap_d = 1'b0;
            end else if (!lock_ctl_q[aperture_pkg::BIT_PCI_DISABLE]) begin
                pci_d = 1'b1;
            end else begin
                none_d = 1'b1;
            end
        end
    end

    // Unmapped register-space writes end with a timeout pulse after a fixed wait.
    // A second store restarts the count, so only the last one reports a timeout.
    always_comb begin
        tmo_cnt_d = tmo_cnt_q;
        tmo_d     = 1'b0;
        if (I_REQ && I_WRITE && in_reg && !(in_dram)
            && (reg_offset[20:0] > 21'h0000ff)) begin
            tmo_cnt_d = 6'(aperture_pkg::TIMEOUT_CYCLES);
        end else if (tmo_cnt_q == 6'h01) begin
            tmo_cnt_d = 6'h0;
            tmo_d     = 1'b1;
        end else if (tmo_cnt_q != 6'h0) begin
            tmo_cnt_d = tmo_cnt_q - 6'h1;
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            hole_q    <= 1'b0;
            dram_q    <= 1'b0;
            regs_q    <= 1'b0;
            pci_q     <= 1'b0;
            none_q    <= 1'b0;
            zero_q    <= 1'b0;
            wr_q      <= 1'b0;
            swap_q    <= 1'b0;
            addr_q    <= 32'h0;
            wdata_q   <= 32'h0;
            tmo_cnt_q <= 6'h0;
            tmo_q     <= 1'b0;
        end else begin
            hole_q    <= hole_d;
            dram_q    <= dram_d;
            regs_q    <= regs_d;
            pci_q     <= pci_d;
            none_q    <= none_d;
            zero_q    <= zero_d;
            wr_q      <= wr_d;
            swap_q    <= swap_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            tmo_cnt_q <= tmo_cnt_d;
            tmo_q     <= tmo_d;
        end
    end

    assign O_REG_RDATA   = rdata_q;
    assign O_SEL_HOLE    = hole_q;
    assign O_SEL_DRAM    = dram_q;
    assign O_SEL_REG     = regs_q;
    assign O_SEL_PCI     = pci_q;
    assign O_SEL_NONE    = none_q;
    assign O_WRITE       = wr_q;
    assign O_ADDR        = addr_q;
    assign O_WDATA       = wdata_q;
    assign O_SWAP        = swap_q;
    assign O_LOAD_ZERO   = zero_q;
    assign O_REG_TIMEOUT = tmo_q;

    // Checks on the registered decode.
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    a_one_target_only: assert property
        ($onehot0({hole_q, dram_q, regs_q, pci_q, none_q}))
        else $error("more than one target selected");
    a_req_gets_target: assert property
        (I_REQ |=> $onehot({hole_q, dram_q, regs_q, pci_q, none_q}))
        else $error("request without exactly one target");
    a_hole_no_pci: assert property
        (I_REQ && !I_WRITE && I_ADDR <= 32'h0000_00ff
         && !lock_ctl_q[0] && dram_base_q > 32'h0000_00ff
         |=> hole_q && O_LOAD_ZERO && !pci_q)
        else $error("hole load reached PCI");
    a_store_not_held: assert property
        (I_REQ && I_WRITE |=> !hole_q)
        else $error("store suppressed by hole");
    a_dram_overrides: assert property
        (I_REQ && dram_base_q == 32'h0 && dram_limit_q >= 32'h0000_00ff
         && I_ADDR <= 32'h0000_00ff |=> dram_q)
        else $error("overlapped hole not ignored");
    a_reg_no_swap: assert property
        (regs_q |-> !O_SWAP)
        else $error("register access swapped");
    a_pci_default: assert property
        (I_REQ && !in_dram && !in_reg && !in_hole && !lock_ctl_q[1] |=> pci_q)
        else $error("default access not sent to PCI");
    a_reg_window: assert property
        (I_REQ && !in_dram && (I_ADDR - reg_start_q) < 32'h0020_0000
         && !(in_hole && hole_active && !I_WRITE) |=> regs_q)
        else $error("register window missed");
    a_timeout_len: assert property
        (tmo_cnt_q == 6'h32 ##1 tmo_cnt_q == 6'h31 |-> ##49 (tmo_q || tmo_cnt_q != 6'h00))
        else $error("write timeout length wrong");
    a_reset_start: assert property
        ($fell(I_RST) |-> reg_start_q == 32'hefe0_0000 && !lock_ctl_q[0])
        else $error("reset values wrong");
    a_pci_off_none: assert property
        (I_REQ && !in_hole && !in_dram && !in_reg && lock_ctl_q[1] |=> none_q && !pci_q)
        else $error("disabled PCI routing still used");
    a_hole_off_bit: assert property
        (I_REQ && lock_ctl_q[0] |=> !hole_q && !O_LOAD_ZERO)
        else $error("disabled hole still suppressed a load");
    a_dram_size_cap: assert property
        (I_REQ && (I_ADDR - dram_base_q) >= 32'h0400_0000 |=> !dram_q)
        else $error("DRAM aperture wider than its cap");
    a_tag_read_only: assert property
        (I_REG_RD && I_REG_ADDR == 8'h14 |=> O_REG_RDATA == aperture_pkg::ICACHE_TAG_VALUE)
        else $error("tag window read back a written value");
    a_unmapped_quiet: assert property
        (I_REG_WR && I_REG_ADDR > 8'h14
         |=> $stable(dram_base_q) && $stable(dram_limit_q) && $stable(reg_start_q)
             && $stable(lock_ctl_q))
        else $error("unmapped register write had a side effect");
    a_timeout_pulse: assert property
        (tmo_q |=> !tmo_q)
        else $error("timeout pulse longer than one cycle");
    a_aperture_aligned: assert property
        (reg_start_q[20:0] == 21'h0)
        else $error("register aperture start not aligned");

    c_hole_load: cover property (hole_q);
    c_dram_hit: cover property (dram_q);
    c_reg_hit: cover property (regs_q);
    c_pci_hit: cover property (pci_q);
    c_timeout: cover property (tmo_q);
endmodule : aperture_decoder

// file: dv/lsu_model.sv
// Purpose: Load/store unit model that issues accesses to the decoder.
// Assumes: One request pulse per access, word sized data only.
// Notes:   Idle lines show inverted values so stale data never matches.
`timescale 1ns/1ps
module lsu_model (
    input  wire logic        i_clk,
    output logic             o_req,
    output logic             o_write,
    output logic [31:0]      o_addr,
    output logic [31:0]      o_wdata
);
    initial begin
        o_req   = 1'h0;
        o_write = 1'h0;
        o_addr  = 32'h0;
        o_wdata = 32'h0;
    end
    // Only whole words are issued, so no narrow access exists here.
    task automatic issue(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_req   <= 1'h1;
        o_write <= w;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_req   <= 1'h0;
        o_write <= ~w;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask : issue
endmodule : lsu_model

// file: dv/cpu_address_aperture_decoder_tb.sv
// Purpose: Self-checking bench for the address aperture decoder.
// Assumes: Byte order select held high so a missing swap bypass shows.
// Notes:   Selects are sampled just after the edge that registers them.
`timescale 1ns/1ps
module cpu_address_aperture_decoder_tb;
    typedef struct packed {
        logic        w;
        logic [31:0] a;
        logic [4:0]  s;
        logic        z;
    } row_s;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        req;
    logic        wrt;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        bos = 1'h1;
    logic [7:0]  raddr = 8'h0;
    logic [31:0] rwdata = 32'h0;
    logic        rwr = 1'h0;
    logic        rrd = 1'h0;
    logic [31:0] rdata;
    logic [4:0]  sel;
    logic        swap;
    logic        lz;
    logic        tmo;
    logic        ow;
    logic [31:0] oa;
    logic [31:0] od;
    logic [31:0] n;
    int          fails = 0;
    int          checks = 0;
    row_s        rows [9];
    always #10 clk = ~clk;
    lsu_model lsu_model_inst (.i_clk(clk), .o_req(req), .o_write(wrt), .o_addr(addr),
        .o_wdata(wdata));
    aperture_decoder aperture_decoder_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_REQ(req),
        .I_WRITE(wrt), .I_ADDR(addr), .I_WDATA(wdata), .I_BYTE_ORDER_SELECT(bos),
        .I_REG_ADDR(raddr), .I_REG_WDATA(rwdata), .I_REG_WR(rwr), .I_REG_RD(rrd),
        .O_REG_RDATA(rdata), .O_SEL_HOLE(sel[4]), .O_SEL_DRAM(sel[3]), .O_SEL_REG(sel[2]),
        .O_SEL_PCI(sel[1]), .O_SEL_NONE(sel[0]), .O_WRITE(ow), .O_ADDR(oa), .O_WDATA(od),
        .O_SWAP(swap), .O_LOAD_ZERO(lz), .O_REG_TIMEOUT(tmo));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        rwr    <= 1'h1;
        raddr  <= a;
        rwdata <= d;
        @(posedge clk);
        rwr    <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rrd   <= 1'h1;
        raddr <= a;
        @(posedge clk);
        rrd   <= 1'h0;
        #1;
        chk(rdata, e);
    endtask : rd
    // Sets are {hole, dram, reg, pci, none}; a full compare proves one-hot.
    task automatic acc(input logic w, input logic [31:0] a, input logic [4:0] s,
        input logic z);
        lsu_model_inst.issue(w, a, ~a);
        #1;
        chk({26'h0, lz, sel}, {26'h0, z, s});
        chk({31'h0, ow}, {31'h0, w});
        chk(oa, a);
        chk(od, ~a);
        if (s === 5'h04) chk({31'h0, swap}, 32'h0);
        else chk({31'h0, swap}, {31'h0, bos});
    endtask : acc
    task automatic wrap_up;
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        fails++;
        wrap_up();
    end
    initial begin
        rows = '{{1'h0, 32'h0000_0010, 5'h10, 1'h1}, {1'h1, 32'h0000_00ff, 5'h02, 1'h0},
            {1'h0, 32'h0000_00ff, 5'h10, 1'h1}, {1'h0, 32'h1000_0000, 5'h08, 1'h0},
            {1'h0, 32'h13ff_fffc, 5'h08, 1'h0}, {1'h0, 32'h1400_0000, 5'h02, 1'h0},
            {1'h0, 32'hefe0_0000, 5'h04, 1'h0}, {1'h0, 32'hefff_fffc, 5'h04, 1'h0},
            {1'h0, 32'hefdf_fffc, 5'h02, 1'h0}};
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        rd(8'h08, aperture_pkg::REG_APERTURE_RESET);
        rd(8'h0c, 32'h0);
        // Apertures stay aligned and disjoint.
        wr(8'h00, 32'h1000_0000);
        wr(8'h04, 32'h13ff_ffff);
        for (int i = 0; i < 9; i++) begin
            acc(rows[i].w, rows[i].a, rows[i].s, rows[i].z);
        end
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14, aperture_pkg::ICACHE_TAG_VALUE);
        wr(8'h40, 32'h1);
        rd(8'h08, aperture_pkg::REG_APERTURE_RESET);
        wr(8'h0c, 32'h1);
        acc(1'h0, 32'h0000_0010, 5'h02, 1'h0);
        wr(8'h0c, 32'h3);
        acc(1'h0, 32'h1400_0000, 5'h01, 1'h0);
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h03ff_ffff);
        acc(1'h0, 32'h0000_0010, 5'h08, 1'h0);
        // Relocation writes the low undefined bits as zero.
        wr(8'h08, 32'h8000_0000);
        rd(8'h08, 32'h8000_0000);
        acc(1'h0, 32'h8000_0004, 5'h04, 1'h0);
        acc(1'h0, 32'hefe0_0000, 5'h02, 1'h0);
        acc(1'h1, 32'h8000_1000, 5'h04, 1'h0);
        n = 32'h0;
        while (tmo !== 1'h1 && n < 32'h40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, 32'(aperture_pkg::TIMEOUT_CYCLES));
        // A reset in mid-run must undo the relocation and the lock bits.
        wr(8'h0c, 32'h3);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(8'h08, aperture_pkg::REG_APERTURE_RESET);
        rd(8'h0c, 32'h0);
        wrap_up();
    end
endmodule : cpu_address_aperture_decoder_tb
